// >>> verilog/gdlc_pkg.sv
// Shared constants, register map and CRC step function for the link check register bank.
`default_nettype none
package gdlc_pkg;
	// ------------------------------------------------------------
	// Widths.
	// ------------------------------------------------------------
	localparam int WORD_W = 16; // Serial word and register width.
	localparam int CRC_W = 8; // CRC accumulator width.
	localparam int IDX_W = 4; // Register index width.
	localparam int FRAME_CNT_W = 4; // Clock pulse counter, modulo sixteen.

	// ------------------------------------------------------------
	// Register indices.
	// ------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CRC_PAIR = 4'h0; // link_crc_pair.
	localparam logic [IDX_W-1:0] IDX_TEST_WORD = 4'h1; // link_test_word.
	localparam logic [IDX_W-1:0] IDX_CHIP_ADDR = 4'h2; // chip_address_store.
	localparam logic [IDX_W-1:0] IDX_INPUT_STATUS = 4'h3; // input_and_state_status.
	localparam logic [IDX_W-1:0] IDX_FIRST_CTRL = 4'h4; // first_control_reg, write side only.

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int RX_CRC_MSB = 15; // Received-data CRC byte.
	localparam int RX_CRC_LSB = 8;
	localparam int TX_CRC_MSB = 7; // Sent-data CRC byte.
	localparam int TX_CRC_LSB = 0;
	localparam int CLEAR_SENT_CRC_BIT = 0; // clear_sent_crc in first_control_reg.
	localparam int CHIP_ADDR_W = 4; // chip_address_field width, bits 3-0.
	localparam int NONINV_BIT = 15; // noninv_input_level.
	localparam int INV_BIT = 14; // inv_input_level.
	localparam int SHORT_EN_BIT = 11; // short_enable_level.
	localparam int OPSTATE_MSB = 8; // operating_state, bits 8-6.
	localparam int OPSTATE_LSB = 6;
	localparam int PWM_FAULT_BIT = 5; // pwm_mismatch_fault.
	localparam int OVERTEMP_BIT = 1; // primary_overtemp_warning.

	// ------------------------------------------------------------
	// Reset values and codes.
	// ------------------------------------------------------------
	localparam logic [CRC_W-1:0] CRC_SEED = 8'hFF; // Accumulator reset value.
	localparam logic [CRC_W-1:0] CRC_POLY = 8'h07; // x^8+x^2+x+1, MSB first.
	localparam logic [WORD_W-1:0] TEST_WORD_RESET = 16'h0000;
	localparam logic [2:0] OPSTATE_CONFIG1 = 3'h1; // First configuration.
	localparam logic [2:0] OPSTATE_CONFIG2 = 3'h2; // Second configuration.
	localparam logic [2:0] OPSTATE_ACTIVE = 3'h3; // Active.
	localparam logic [CHIP_ADDR_W-1:0] CHIP_ADDR_RESET = 4'h0;

	// Folds one 16-bit word into the CRC, most significant bit first.
	function automatic logic [CRC_W-1:0] gdlc_crc_word(input logic [CRC_W-1:0] crcIn,
		input logic [WORD_W-1:0] word);
		logic [CRC_W-1:0] c;
		logic fb;
		c = crcIn;
		fb = 1'b0;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			fb = c[CRC_W-1] ^ word[i];
			c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction
endpackage
`default_nettype wire

// >>> verilog/gdlc_crc_if.sv
// Carrier between the register bank and one CRC accumulator.
`timescale 1ns/1ps
`default_nettype none
interface gdlc_crc_if;
	import gdlc_pkg::*;
	logic init; // Reload the seed; wins over a step.
	logic step; // Fold in one word.
	logic [WORD_W-1:0] word; // Word to fold in.
	logic [CRC_W-1:0] crc; // Current accumulator value.
	modport engine (input init, input step, input word, output crc);
	modport user (output init, output step, output word, input crc);
endinterface
`default_nettype wire

// >>> verilog/gdlc_crc8.sv
// Eight-bit CRC accumulator over 16-bit serial words.
`timescale 1ns/1ps
`default_nettype none
module gdlc_crc8 import gdlc_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	gdlc_crc_if.engine bus
);
	logic [CRC_W-1:0] crc_reg; // Accumulator.

	// Seed reload has priority, otherwise fold in the offered word.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			crc_reg <= CRC_SEED;
		end else if (ce) begin
			if (bus.init) begin
				crc_reg <= CRC_SEED;
			end else if (bus.step) begin
				crc_reg <= gdlc_crc_word(crc_reg, bus.word);
			end
		end
	end

	assign bus.crc = crc_reg;
endmodule // gdlc_crc8
`default_nettype wire

// >>> verilog/gdlc_frame_check.sv
// Counts serial clock pulses per chip-select frame and judges each frame at its end.
`timescale 1ns/1ps
`default_nettype none
module gdlc_frame_check import gdlc_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic csN,
	input wire logic sclkPulse,
	output logic frameOk,
	output logic frameBad
);
	logic csPrev_reg; // Chip select one cycle ago.
	logic [FRAME_CNT_W-1:0] pulseCnt_reg; // Pulses modulo sixteen.
	logic frameEnd; // Chip select rising.

	assign frameEnd = csN & ~csPrev_reg;

	// Tracks chip select to find the frame edges.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			csPrev_reg <= 1'b1;
		end else if (ce) begin
			csPrev_reg <= csN;
		end
	end

	// Counts pulses inside a frame; a new frame starts from zero.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pulseCnt_reg <= '0;
		end else if (ce) begin
			if (!csN && csPrev_reg) begin
				pulseCnt_reg <= sclkPulse ? 4'h1 : 4'h0;
			end else if (!csN && sclkPulse) begin
				pulseCnt_reg <= pulseCnt_reg + 4'h1;
			end
		end
	end

	// A frame is whole when its pulse count is a multiple of sixteen.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			frameOk <= 1'b0;
			frameBad <= 1'b0;
		end else if (ce) begin
			frameOk <= frameEnd && (pulseCnt_reg == '0);
			frameBad <= frameEnd && (pulseCnt_reg != '0);
		end
	end
endmodule // gdlc_frame_check
`default_nettype wire

// >>> verilog/gdlc_regs.sv
// Link check and status register bank of the isolated gate driver primary side.
// What this block does
// - Accumulate CRC over received words, upper byte.
// - Received-CRC write compares, then reseeds accumulator.
// - Compare mismatch sets serial-link fault.
// - Accumulate CRC over sent words, lower byte.
// - clear_sent_crc write of one reseeds sent CRC.
// - Non-zero test word write raises config fault.
// - Chip address loads only in first configuration.
// - Status shows live input and short-enable levels.
// - Operating state field, resets to first configuration.
// - Secondary PWM differing from input sets fault.
// - Over-temperature sets primary warning bit.
// - Warning clears on read only once cooled.
// - Reserved bits read as zero.
// - Frame without sixteen-multiple pulses sets link fault.
// - Link fault clears after valid command, then read.
`timescale 1ns/1ps
`default_nettype none
module gdlc_regs import gdlc_pkg::*; (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [IDX_W-1:0] regIdx,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [WORD_W-1:0] regWdata,
	output logic [WORD_W-1:0] regRdata,
	input wire logic rxWordValid,
	input wire logic [WORD_W-1:0] rxWord,
	input wire logic txWordValid,
	input wire logic [WORD_W-1:0] txWord,
	input wire logic csN,
	input wire logic sclkPulse,
	input wire logic secondStatusRead,
	input wire logic noninvInputLevel,
	input wire logic invInputLevel,
	input wire logic activeShortEnablePin,
	input wire logic secondaryPwmLevel,
	input wire logic overTemp,
	input wire logic [2:0] operatingStateIn,
	input wire logic serialAddrMode,
	input wire logic chipAddrLoad,
	input wire logic [CHIP_ADDR_W-1:0] chipAddrIn,
	output logic serialLinkFault,
	output logic configCrcFault
);
	// ------------------------------------------------------------
	// Decode and CRC engines.
	// ------------------------------------------------------------
	gdlc_crc_if rxIf(); // Received-data accumulator link.
	gdlc_crc_if txIf(); // Sent-data accumulator link.

	logic crcWrite; // Host writes the received-CRC byte.
	logic ctrlClearTx; // Host writes clear_sent_crc as one.
	logic testWrite; // Host writes the test word.
	logic inputStatusRead; // Host reads the input and state status.
	logic crcMismatch; // Written byte differs from the accumulator.
	logic frameOk; // Frame ended with a whole word count.
	logic frameBad; // Frame ended with a broken word count.

	assign crcWrite = regWr && (regIdx == IDX_CRC_PAIR);
	assign ctrlClearTx = regWr && (regIdx == IDX_FIRST_CTRL) && regWdata[CLEAR_SENT_CRC_BIT];
	assign testWrite = regWr && (regIdx == IDX_TEST_WORD);
	assign inputStatusRead = regRd && (regIdx == IDX_INPUT_STATUS);
	assign crcMismatch = crcWrite && (regWdata[RX_CRC_MSB:RX_CRC_LSB] != rxIf.crc);

	// The write itself reseeds; its own word is not folded in.
	assign rxIf.init = crcWrite;
	assign rxIf.step = rxWordValid;
	assign rxIf.word = rxWord;
	assign txIf.init = ctrlClearTx;
	assign txIf.step = txWordValid;
	assign txIf.word = txWord;

	// Both directions share one engine design and seed.
	gdlc_crc8 rxCrcUnit (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.bus(rxIf.engine)
	);

	gdlc_crc8 txCrcUnit (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.bus(txIf.engine)
	);

	gdlc_frame_check frameUnit (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.csN(csN),
		.sclkPulse(sclkPulse),
		.frameOk(frameOk),
		.frameBad(frameBad)
	);

	// ------------------------------------------------------------
	// Serial-link fault.
	// ------------------------------------------------------------
	logic clearArmed_reg; // A valid command has been seen since the last set or second status read.

	// Arms the clear on a whole frame; a new fault disarms it.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			clearArmed_reg <= 1'b0;
		end else if (ce) begin
			if (frameBad || crcMismatch) begin
				clearArmed_reg <= 1'b0;
			end else if (frameOk) begin
				clearArmed_reg <= 1'b1;
			end else if (secondStatusRead) begin
				clearArmed_reg <= 1'b0;
			end
		end
	end

	// Setting wins over the read that would clear it.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			serialLinkFault <= 1'b0;
		end else if (ce) begin
			if (crcMismatch || frameBad) begin
				serialLinkFault <= 1'b1;
			end else if (secondStatusRead && clearArmed_reg) begin
				serialLinkFault <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Test word and configuration fault.
	// ------------------------------------------------------------
	logic [WORD_W-1:0] testWord_reg; // link_test_word contents.

	// Plain read/write storage.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			testWord_reg <= TEST_WORD_RESET;
		end else if (ce && testWrite) begin
			testWord_reg <= regWdata;
		end
	end

	// Sticky until the second status word is read; a new non-zero write wins.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			configCrcFault <= 1'b0;
		end else if (ce) begin
			if (testWrite && (regWdata != '0)) begin
				configCrcFault <= 1'b1;
			end else if (secondStatusRead) begin
				configCrcFault <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Chip address and operating state.
	// ------------------------------------------------------------
	logic [CHIP_ADDR_W-1:0] chipAddr_reg; // chip_address_field.
	logic [2:0] opState_reg; // operating_state.

	// Loads only in first configuration under serial addressing.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chipAddr_reg <= CHIP_ADDR_RESET;
		end else if (ce && chipAddrLoad && serialAddrMode && (opState_reg == OPSTATE_CONFIG1)) begin
			chipAddr_reg <= chipAddrIn;
		end
	end

	// Follows the device sequencer; every code is shown as given.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			opState_reg <= OPSTATE_CONFIG1;
		end else if (ce) begin
			opState_reg <= operatingStateIn;
		end
	end

	// ------------------------------------------------------------
	// Status flags.
	// ------------------------------------------------------------
	logic pwmFault_reg; // pwm_mismatch_fault.
	logic overtempWarn_reg; // primary_overtemp_warning.

	// Sticky mismatch; a status read clears it once paths agree.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwmFault_reg <= 1'b0;
		end else if (ce) begin
			if (secondaryPwmLevel != noninvInputLevel) begin
				pwmFault_reg <= 1'b1;
			end else if (inputStatusRead) begin
				pwmFault_reg <= 1'b0;
			end
		end
	end

	// Heat sets; a read clears only when already cool.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			overtempWarn_reg <= 1'b0;
		end else if (ce) begin
			if (overTemp) begin
				overtempWarn_reg <= 1'b1;
			end else if (inputStatusRead) begin
				overtempWarn_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------
	logic [WORD_W-1:0] readMux; // Selected register image.

	// Builds the image; every bit not assigned reads zero.
	always_comb begin
		readMux = '0;
		unique case (regIdx)
			IDX_CRC_PAIR: begin
				readMux[RX_CRC_MSB:RX_CRC_LSB] = rxIf.crc;
				readMux[TX_CRC_MSB:TX_CRC_LSB] = txIf.crc;
			end
			IDX_TEST_WORD: begin
				readMux = testWord_reg;
			end
			IDX_CHIP_ADDR: begin
				readMux[CHIP_ADDR_W-1:0] = chipAddr_reg;
			end
			IDX_INPUT_STATUS: begin
				readMux[NONINV_BIT] = noninvInputLevel;
				readMux[INV_BIT] = invInputLevel;
				readMux[SHORT_EN_BIT] = activeShortEnablePin;
				readMux[OPSTATE_MSB:OPSTATE_LSB] = opState_reg;
				readMux[PWM_FAULT_BIT] = pwmFault_reg;
				readMux[OVERTEMP_BIT] = overtempWarn_reg;
			end
			default: begin
				readMux = '0;
			end
		endcase
	end

	// Read data appears the cycle after the read strobe.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= '0;
		end else if (ce && regRd) begin
			regRdata <= readMux;
		end
	end

	// ------------------------------------------------------------
	// Assertions.
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	rx_crc_fold_a: assert property (ce && rxWordValid && !crcWrite |=>
		rxIf.crc == gdlc_crc_word($past(rxIf.crc), $past(rxWord)))
		else $error("Received CRC did not fold the word.");
	rx_crc_reseed_a: assert property (ce && crcWrite |=> rxIf.crc == CRC_SEED)
		else $error("Received CRC not reseeded after write.");
	crc_mismatch_a: assert property (ce && crcMismatch |=> serialLinkFault)
		else $error("CRC mismatch did not set link fault.");
	tx_crc_fold_a: assert property (ce && txWordValid && !ctrlClearTx |=>
		txIf.crc == gdlc_crc_word($past(txIf.crc), $past(txWord)))
		else $error("Sent CRC did not fold the word.");
	tx_crc_clear_a: assert property (ce && ctrlClearTx |=> txIf.crc == CRC_SEED)
		else $error("Sent CRC not reseeded by control write.");
	test_fault_a: assert property (ce && testWrite && regWdata != '0 |=> configCrcFault)
		else $error("Non-zero test write did not raise fault.");
	chip_addr_hold_a: assert property (opState_reg != OPSTATE_CONFIG1 |=> $stable(chipAddr_reg))
		else $error("Chip address changed outside first configuration.");
	input_levels_a: assert property (ce && inputStatusRead |=>
		regRdata[NONINV_BIT] == $past(noninvInputLevel) && regRdata[SHORT_EN_BIT] == $past(activeShortEnablePin))
		else $error("Status does not show live pin levels.");
	pwm_fault_a: assert property (ce && secondaryPwmLevel != noninvInputLevel |=> pwmFault_reg)
		else $error("PWM mismatch did not set fault.");
	overtemp_set_a: assert property (ce && overTemp |=> overtempWarn_reg)
		else $error("Over-temperature did not set warning.");
	overtemp_hold_a: assert property (overtempWarn_reg && overTemp |=> overtempWarn_reg)
		else $error("Warning cleared while still hot.");
	addr_reserved_a: assert property (ce && regRd && regIdx == IDX_CHIP_ADDR |=>
		regRdata[WORD_W-1:CHIP_ADDR_W] == '0)
		else $error("Reserved address bits read non-zero.");
	frame_fault_a: assert property (ce && frameBad |=> serialLinkFault)
		else $error("Broken frame did not set link fault.");
	link_clear_a: assert property (serialLinkFault && !clearArmed_reg |=> serialLinkFault)
		else $error("Link fault cleared without valid command.");

	mismatch_seen_c: cover property (ce && crcMismatch ##1 serialLinkFault);
	warn_cleared_c: cover property (overtempWarn_reg && !overTemp && ce && inputStatusRead ##1 !overtempWarn_reg);
	addr_loaded_c: cover property (ce && chipAddrLoad && serialAddrMode && opState_reg == OPSTATE_CONFIG1);
endmodule // gdlc_regs
`default_nettype wire

// >>> test/gdlc_host_model.sv
// Host controller model: register port, chip-select frames and serial words.
`timescale 1ns/1ps
`default_nettype none
module gdlc_host_model import gdlc_pkg::*; (
	input wire logic sys_clk,
	input wire logic [WORD_W-1:0] regRdata,
	output logic [IDX_W-1:0] regIdx,
	output logic regWr,
	output logic regRd,
	output logic [WORD_W-1:0] regWdata,
	output logic rxWordValid,
	output logic [WORD_W-1:0] rxWord,
	output logic txWordValid,
	output logic [WORD_W-1:0] txWord,
	output logic csN,
	output logic sclkPulse,
	output logic secondStatusRead
);
	// Idle at time zero: deselected, no strobes.
	initial begin
		{regIdx, regWr, regRd, regWdata} = '0;
		{rxWordValid, rxWord, txWordValid, txWord} = '0;
		{csN, sclkPulse, secondStatusRead} = 3'b100;
	end

	// One write, held for exactly the taking edge; data is scrambled once released.
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] d);
		@(posedge sys_clk) #1;
		regIdx = idx;
		regWdata = d;
		regWr = 1'b1;
		@(posedge sys_clk) #1;
		regWr = 1'b0;
		regWdata = ~d;
	endtask

	// One read; the answer is taken once the answering edge has settled.
	task automatic rd(input logic [IDX_W-1:0] idx, output logic [WORD_W-1:0] d);
		@(posedge sys_clk) #1;
		regIdx = idx;
		regRd = 1'b1;
		@(posedge sys_clk) #1;
		regRd = 1'b0;
		d = regRdata;
	endtask

	// One frame of n clock pulses; a whole word rides on the last pulse when asked.
	task automatic frame(input int n, input logic [WORD_W-1:0] rx, input logic [WORD_W-1:0] tx, input bit word);
		@(posedge sys_clk) #1;
		csN = 1'b0;
		for (int i = 0; i < n; i++) begin
			sclkPulse = 1'b1;
			rxWordValid = word && (i == n - 1);
			txWordValid = word && (i == n - 1);
			rxWord = rx;
			txWord = tx;
			@(posedge sys_clk) #1;
		end
		if (n == 0) begin
			@(posedge sys_clk) #1;
		end
		{sclkPulse, rxWordValid, txWordValid} = 3'b000;
		rxWord = ~rx;
		txWord = ~tx;
		csN = 1'b1;
		@(posedge sys_clk) #1;
	endtask

	// Host read of the second status register, seen as a one-cycle pulse.
	task automatic status2Read();
		@(posedge sys_clk) #1;
		secondStatusRead = 1'b1;
		@(posedge sys_clk) #1;
		secondStatusRead = 1'b0;
	endtask
endmodule // gdlc_host_model
`default_nettype wire

// >>> test/gdlc_regs_tb_top.sv
// Self-checking testbench of the link check and status register bank.
`timescale 1ns/1ps
`default_nettype none
module gdlc_regs_tb_top import gdlc_pkg::*; ;
	// ------------------------------------------------------------
	// Signals.
	// ------------------------------------------------------------
	logic sys_clk, sys_rst, ce, overTemp, serialAddrMode, chipAddrLoad;
	logic noninv, inv, shortEn, pwmSec, serialLinkFault, configCrcFault;
	logic [2:0] opState;
	logic [3:0] chipAddr;
	logic [IDX_W-1:0] regIdx;
	logic regWr, regRd, rxWordValid, txWordValid, csN, sclkPulse, secondStatusRead;
	logic [WORD_W-1:0] regWdata, regRdata, rxWord, txWord, d, tw;
	logic [7:0] rxC, txC;
	logic [31:0] rnd = 32'h63371FFC; // Fixed seed.
	int nMismatch = 0;
	int nCompared = 0;

	gdlc_host_model u_host (.sys_clk(sys_clk), .regRdata(regRdata), .regIdx(regIdx), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .rxWordValid(rxWordValid), .rxWord(rxWord),
		.txWordValid(txWordValid), .txWord(txWord), .csN(csN), .sclkPulse(sclkPulse),
		.secondStatusRead(secondStatusRead));
	gdlc_regs u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .regIdx(regIdx), .regWr(regWr),
		.regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .rxWordValid(rxWordValid),
		.rxWord(rxWord), .txWordValid(txWordValid), .txWord(txWord), .csN(csN), .sclkPulse(sclkPulse),
		.secondStatusRead(secondStatusRead), .noninvInputLevel(noninv), .invInputLevel(inv),
		.activeShortEnablePin(shortEn), .secondaryPwmLevel(pwmSec), .overTemp(overTemp),
		.operatingStateIn(opState), .serialAddrMode(serialAddrMode), .chipAddrLoad(chipAddrLoad),
		.chipAddrIn(chipAddr), .serialLinkFault(serialLinkFault), .configCrcFault(configCrcFault));

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected CRC after one word, seed and polynomial as the host must use them.
	function automatic logic [7:0] crcOf(input logic [7:0] c, input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	// Expected status image from the pins now driven.
	function automatic logic [15:0] stat(input logic [2:0] op, input logic pwm, input logic ot);
		return {noninv, inv, 2'b00, shortEn, 2'b00, op, pwm, 3'b000, ot, 1'b0};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		nCompared++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic endSim();
		$display("compared %0d, mismatches %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Clock of 50 ns and a watchdog well beyond the run.
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#(20000 * 50);
		nMismatch++;
		endSim();
	end

	// ------------------------------------------------------------
	// Tests.
	// ------------------------------------------------------------
	initial begin
		{ce, overTemp, serialAddrMode, chipAddrLoad} = 4'b1000;
		{noninv, inv, shortEn, pwmSec, chipAddr} = '0;
		opState = OPSTATE_CONFIG1;
		sys_rst = 1'b1;
		tick(12);
		sys_rst = 1'b0;
		u_host.rd(IDX_CRC_PAIR, d);
		chk16(d, 16'hFFFF);
		u_host.rd(IDX_TEST_WORD, d);
		chk16(d, 16'h0000);
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, 16'h0040);
		for (int i = 5; i < 16; i++) begin
			u_host.rd(4'(i), d);
			chk16(d, 16'h0000);
		end
		$display("test reset done");
		// Random words both ways, then compare writes and reseeds.
		rxC = CRC_SEED;
		txC = CRC_SEED;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			u_host.frame(16, rnd[31:16], rnd[15:0], 1'b1);
			rxC = crcOf(rxC, rnd[31:16]);
			txC = crcOf(txC, rnd[15:0]);
		end
		u_host.rd(IDX_CRC_PAIR, d);
		chk16(d, {rxC, txC});
		u_host.wr(IDX_CRC_PAIR, {rxC, 8'h00});
		chk1(serialLinkFault, 1'b0);
		u_host.wr(IDX_FIRST_CTRL, 16'h0001);
		u_host.rd(IDX_CRC_PAIR, d);
		chk16(d, 16'hFFFF);
		rnd = lfsr(rnd);
		u_host.frame(16, rnd[15:0], rnd[31:16], 1'b1);
		u_host.wr(IDX_CRC_PAIR, {crcOf(CRC_SEED, rnd[15:0]) ^ 8'h01, 8'h00});
		chk1(serialLinkFault, 1'b1);
		$display("test crc done");
		// Fault clearing needs a valid frame first; bad counts set it.
		u_host.status2Read();
		chk1(serialLinkFault, 1'b1);
		u_host.frame(32, 16'h0000, 16'h0000, 1'b0);
		tick(2);
		u_host.status2Read();
		chk1(serialLinkFault, 1'b0);
		u_host.frame(15, 16'h0000, 16'h0000, 1'b0);
		tick(2);
		chk1(serialLinkFault, 1'b1);
		u_host.frame(0, 16'h0000, 16'h0000, 1'b0);
		tick(2);
		u_host.status2Read();
		chk1(serialLinkFault, 1'b0);
		$display("test frame done");
		// Test word.
		rnd = lfsr(rnd);
		tw = rnd[15:0] | 16'h0100;
		u_host.wr(IDX_TEST_WORD, tw);
		chk1(configCrcFault, 1'b1);
		u_host.rd(IDX_TEST_WORD, d);
		chk16(d, tw);
		u_host.status2Read();
		u_host.wr(IDX_TEST_WORD, 16'h0000);
		chk1(configCrcFault, 1'b0);
		// With the clock enable low the write and the read below must both be ignored.
		ce = 1'b0;
		u_host.wr(IDX_TEST_WORD, 16'h5A5A);
		u_host.rd(IDX_TEST_WORD, d);
		chk16(d, tw);
		chk1(configCrcFault, 1'b0);
		ce = 1'b1;
		u_host.rd(IDX_TEST_WORD, d);
		chk16(d, 16'h0000);
		$display("test word done");
		// Status image over every state code and random pin levels.
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			{noninv, inv, shortEn} = rnd[2:0];
			pwmSec = rnd[2]; // Secondary path follows the non-inverting input, so no fault.
			opState = 3'(i);
			tick(1);
			u_host.rd(IDX_INPUT_STATUS, d);
			chk16(d, stat(3'(i), 1'b0, 1'b0));
		end
		pwmSec = ~noninv;
		tick(1);
		pwmSec = noninv;
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b1, 1'b0));
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b0, 1'b0));
		overTemp = 1'b1;
		tick(2);
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b0, 1'b1));
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b0, 1'b1));
		overTemp = 1'b0;
		tick(1);
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b0, 1'b1));
		u_host.rd(IDX_INPUT_STATUS, d);
		chk16(d, stat(opState, 1'b0, 1'b0));
		$display("test status done");
		// Chip address loads only in first configuration with serial addressing.
		opState = OPSTATE_CONFIG1;
		serialAddrMode = 1'b1;
		rnd = lfsr(rnd);
		chipAddr = rnd[3:0];
		tick(2);
		chipAddrLoad = 1'b1;
		tick(1);
		chipAddrLoad = 1'b0;
		u_host.wr(IDX_CHIP_ADDR, 16'hFFFF);
		u_host.rd(IDX_CHIP_ADDR, d);
		chk16(d, {12'h000, rnd[3:0]});
		for (int j = 0; j < 2; j++) begin
			opState = (j == 0) ? OPSTATE_ACTIVE : OPSTATE_CONFIG1;
			serialAddrMode = (j == 0);
			chipAddr = ~rnd[3:0];
			tick(2);
			chipAddrLoad = 1'b1;
			tick(1);
			chipAddrLoad = 1'b0;
			u_host.rd(IDX_CHIP_ADDR, d);
			chk16(d, {12'h000, rnd[3:0]});
		end
		$display("test address done");
		endSim();
	end
endmodule // gdlc_regs_tb_top
`default_nettype wire
